// ==== common/carsp_pkg.sv ====
// Shared constants and types for the center-aligned read strobe port
package carsp_pkg;

  localparam int CARSP_DQ_W       = 8;
  localparam int CARSP_CA_BYTES   = 6;
  localparam int CARSP_CA_W       = 48;
  localparam int CARSP_CA_RW_BIT  = 47;
  localparam int CARSP_LAT_CLOCKS = 6;
  localparam int CARSP_CNT_W      = 8;
  localparam int CARSP_ADDR_W     = 8;

  localparam logic CARSP_HW_RST_N_RST = 1'b1;
  localparam logic CARSP_MASK_LVL     = 1'b1;

  typedef enum logic [2:0] {
    CARSP_ST_IDLE = 3'b000,
    CARSP_ST_CA   = 3'b001,
    CARSP_ST_LAT  = 3'b010,
    CARSP_ST_RD   = 3'b011,
    CARSP_ST_WR   = 3'b100
  } carsp_state_e;

  typedef struct packed {
    logic                  cs_n;
    logic                  bus_clk;
    logic                  bus_clk_comp;
    logic                  shifted_clk;
    logic                  shifted_clk_comp;
    logic                  rw_strobe;
    logic [CARSP_DQ_W-1:0] dq;
  } carsp_pin_in_s;

  typedef struct packed {
    logic [CARSP_DQ_W-1:0] dq;
    logic                  dq_oe_n;
    logic                  rw_strobe;
    logic                  rw_strobe_oe_n;
  } carsp_pin_out_s;

  localparam carsp_pin_in_s CARSP_PIN_IN_RST = '{cs_n: 1'b1, default: '0};
  localparam carsp_pin_out_s CARSP_PIN_OUT_RST = '{
    dq: 8'h00, dq_oe_n: 1'b1, rw_strobe: 1'b0, rw_strobe_oe_n: 1'b1};

endpackage

// ==== src/carsp_mem.sv ====
// Byte array behind the port, registered read data
`timescale 1ns/1ps
module carsp_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  // Clock
  input  wire logic              clk_sys,
  // Write side
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  // Read side
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata_ff
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // No reset on the array so it maps onto plain RAM
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_ff <= mem[raddr];
  end

endmodule

// ==== src/carsp_port.sv ====
// Device side of the DDR bus port with center-aligned read strobe
//
// Overview of operation
// - Fitted option times strobe from shifted clock
// - Shifted clock ignored during writes
// - Shifted clock differential or single-ended per variant
// - Select falling edge starts a transaction
// - Select rising edge abandons the transaction
// - Transfers referenced to bus clock crossing
// - Read bytes aligned with shifted-clock strobe edges
// - Write strobe is byte mask input
// - Strobe shows extra latency at transaction start
// - Command-address and data share 8-bit bus
// - Hardware reset low returns to idle
// - Hardware reset low floats strobe and data
// - Unconnected hardware reset reads as deasserted
// - Device drives strobe throughout reads
`timescale 1ns/1ps
module carsp_port
  import carsp_pkg::*;
#(
  parameter bit STROBE_OPT = 1'b1,
  parameter bit DIFF_CLK   = 1'b1,
  parameter int LAT_CLOCKS = CARSP_LAT_CLOCKS,
  parameter int ADDR_W     = CARSP_ADDR_W
) (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rstn,
  // Hardware reset pin
  input  wire logic           hw_reset_n,
  // Core refresh status
  input  wire logic           extra_latency_req,
  // Bus pins
  input  wire carsp_pin_in_s  bus_pins,
  output carsp_pin_out_s      drive_pins
);

  function automatic logic clk_lvl(input logic tru, input logic comp, input bit diff);
    clk_lvl = diff ? (tru & ~comp) : tru;
  endfunction

  function automatic logic [CARSP_CNT_W-1:0] lat_edges(input logic extra);
    lat_edges = extra ? CARSP_CNT_W'(4 * LAT_CLOCKS) : CARSP_CNT_W'(2 * LAT_CLOCKS);
  endfunction

  logic                    hw_rst_s1_ff;
  logic                    hw_rst_s2_ff;
  carsp_pin_in_s           pin_s1_ff;
  carsp_pin_in_s           pin_s2_ff;
  logic                    bclk_prev_ff;
  logic                    sclk_prev_ff;
  logic                    cs_prev_ff;
  carsp_state_e            state_ff;
  logic [CARSP_CNT_W-1:0]  cnt_ff;
  logic [CARSP_CA_W-1:0]   ca_ff;
  logic [CARSP_CA_W-1:0]   nxt_ca;
  logic [ADDR_W-1:0]       addr_ff;
  logic                    is_read_ff;
  logic                    extra_ff;
  carsp_pin_out_s          pout_ff;
  logic                    hw_active;
  logic                    bclk_lvl;
  logic                    sclk_lvl;
  logic                    bus_edge;
  logic                    psc_edge;
  logic                    strobe_src;
  logic                    cs_fall;
  logic                    cs_rise;
  logic                    lat_done;
  logic                    mem_we;
  logic [CARSP_DQ_W-1:0]   mem_rdata;

  // Pull-up level at power-on keeps an open pin deasserted
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hw_rst_s1_ff <= CARSP_HW_RST_N_RST;
      hw_rst_s2_ff <= CARSP_HW_RST_N_RST;
    end else begin
      hw_rst_s1_ff <= hw_reset_n;
      hw_rst_s2_ff <= hw_rst_s1_ff;
    end
  end

  // All pins cross into clk_sys through two stages
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_s1_ff <= CARSP_PIN_IN_RST;
      pin_s2_ff <= CARSP_PIN_IN_RST;
    end else begin
      pin_s1_ff <= bus_pins;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign hw_active = ~hw_rst_s2_ff;
  assign bclk_lvl  = clk_lvl(pin_s2_ff.bus_clk, pin_s2_ff.bus_clk_comp, DIFF_CLK);
  assign sclk_lvl  = clk_lvl(pin_s2_ff.shifted_clk, pin_s2_ff.shifted_clk_comp,
                             DIFF_CLK);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bclk_prev_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      cs_prev_ff   <= 1'b1;
    end else begin
      bclk_prev_ff <= bclk_lvl;
      sclk_prev_ff <= sclk_lvl;
      cs_prev_ff   <= pin_s2_ff.cs_n;
    end
  end

  // Both edges count: data moves at double rate
  assign bus_edge   = bclk_lvl ^ bclk_prev_ff;
  assign psc_edge   = sclk_lvl ^ sclk_prev_ff;
  assign strobe_src = STROBE_OPT ? psc_edge : bus_edge;
  assign cs_fall    = cs_prev_ff & ~pin_s2_ff.cs_n;
  assign cs_rise    = ~cs_prev_ff & pin_s2_ff.cs_n;
  assign lat_done   = (cnt_ff == lat_edges(extra_ff) - CARSP_CNT_W'(1));
  assign nxt_ca     = {ca_ff[CARSP_CA_W-CARSP_DQ_W-1:0], pin_s2_ff.dq};

  // Transaction sequencing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff   <= CARSP_ST_IDLE;
      cnt_ff     <= '0;
      ca_ff      <= '0;
      addr_ff    <= '0;
      is_read_ff <= 1'b0;
      extra_ff   <= 1'b0;
    end else if (hw_active) begin
      state_ff <= CARSP_ST_IDLE;
      cnt_ff   <= '0;
    end else if (cs_rise) begin
      state_ff <= CARSP_ST_IDLE;
      cnt_ff   <= '0;
    end else if (cs_fall) begin
      state_ff <= CARSP_ST_CA;
      cnt_ff   <= '0;
      extra_ff <= extra_latency_req;
    end else begin
      case (state_ff)
        CARSP_ST_CA: begin
          if (bus_edge) begin
            ca_ff <= nxt_ca;
            if (cnt_ff == CARSP_CNT_W'(CARSP_CA_BYTES - 1)) begin
              state_ff   <= CARSP_ST_LAT;
              cnt_ff     <= '0;
              addr_ff    <= nxt_ca[ADDR_W-1:0];
              is_read_ff <= nxt_ca[CARSP_CA_RW_BIT];
            end else begin
              cnt_ff <= cnt_ff + CARSP_CNT_W'(1);
            end
          end
        end
        CARSP_ST_LAT: begin
          if (bus_edge) begin
            if (lat_done) begin
              state_ff <= is_read_ff ? CARSP_ST_RD : CARSP_ST_WR;
              cnt_ff   <= '0;
            end else begin
              cnt_ff <= cnt_ff + CARSP_CNT_W'(1);
            end
          end
        end
        CARSP_ST_RD: begin
          if (strobe_src) begin
            addr_ff <= addr_ff + ADDR_W'(1);
          end
        end
        CARSP_ST_WR: begin
          if (bus_edge) begin
            addr_ff <= addr_ff + ADDR_W'(1);
          end
        end
        default: begin
          state_ff <= CARSP_ST_IDLE;
        end
      endcase
    end
  end

  // Shifted clock is never looked at outside a read
  assign mem_we = (state_ff == CARSP_ST_WR) && bus_edge && !cs_rise && !hw_active &&
                  (pin_s2_ff.rw_strobe != CARSP_MASK_LVL);

  carsp_mem #(
    .DATA_W (CARSP_DQ_W),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk_sys  (clk_sys),
    .we       (mem_we),
    .waddr    (addr_ff),
    .wdata    (pin_s2_ff.dq),
    .raddr    (addr_ff),
    .rdata_ff (mem_rdata)
  );

  // Pin drive; read data prefetched one cycle ahead of the next edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pout_ff <= CARSP_PIN_OUT_RST;
    end else if (hw_active) begin
      pout_ff <= CARSP_PIN_OUT_RST;
    end else if (cs_rise) begin
      pout_ff <= CARSP_PIN_OUT_RST;
    end else if (cs_fall) begin
      pout_ff.rw_strobe      <= extra_latency_req;
      pout_ff.rw_strobe_oe_n <= 1'b0;
      pout_ff.dq_oe_n        <= 1'b1;
    end else if (state_ff == CARSP_ST_LAT && bus_edge && lat_done) begin
      pout_ff.rw_strobe      <= 1'b0;
      pout_ff.rw_strobe_oe_n <= ~is_read_ff;
    end else if (state_ff == CARSP_ST_RD && strobe_src) begin
      pout_ff.dq        <= mem_rdata;
      pout_ff.dq_oe_n   <= 1'b0;
      pout_ff.rw_strobe <= ~pout_ff.rw_strobe;
    end
  end

  assign drive_pins = pout_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_hw_idle;
    hw_active |=> state_ff == CARSP_ST_IDLE;
  endproperty
  a_hw_idle: assert property (p_hw_idle) else $error("reset pin did not idle");

  property p_hw_hiz;
    hw_active |=> pout_ff.dq_oe_n && pout_ff.rw_strobe_oe_n;
  endproperty
  a_hw_hiz: assert property (p_hw_hiz) else $error("pins driven under reset");

  property p_cs_start;
    cs_fall && !hw_active |=> state_ff == CARSP_ST_CA && cnt_ff == '0;
  endproperty
  a_cs_start: assert property (p_cs_start) else $error("select fall missed");

  property p_cs_abort;
    cs_rise && !hw_active |=> state_ff == CARSP_ST_IDLE && pout_ff.dq_oe_n;
  endproperty
  a_cs_abort: assert property (p_cs_abort) else $error("select rise not abandoned");

  property p_lat_flag;
    cs_fall && !hw_active |=> !pout_ff.rw_strobe_oe_n &&
      pout_ff.rw_strobe == $past(extra_latency_req);
  endproperty
  a_lat_flag: assert property (p_lat_flag) else $error("latency flag wrong");

  property p_rd_own;
    state_ff == CARSP_ST_RD |-> !pout_ff.rw_strobe_oe_n;
  endproperty
  a_rd_own: assert property (p_rd_own) else $error("strobe released in read");

  property p_rd_edge;
    state_ff == CARSP_ST_RD && strobe_src && !cs_rise && !hw_active |=>
      pout_ff.rw_strobe != $past(pout_ff.rw_strobe) && pout_ff.dq == $past(mem_rdata);
  endproperty
  a_rd_edge: assert property (p_rd_edge) else $error("read byte not on strobe");

  property p_rd_src;
    state_ff == CARSP_ST_RD && !strobe_src && !cs_rise && !hw_active |=>
      $stable(pout_ff.rw_strobe) && $stable(pout_ff.dq);
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("strobe moved off clock");

  property p_rd_ddr;
    state_ff == CARSP_ST_RD && strobe_src && !cs_rise && !hw_active |=>
      addr_ff == ADDR_W'($past(addr_ff) + 1);
  endproperty
  a_rd_ddr: assert property (p_rd_ddr) else $error("read byte per edge lost");

  property p_wr_psc;
    state_ff == CARSP_ST_WR && !cs_rise && !hw_active |=>
      pout_ff.rw_strobe_oe_n && $stable(pout_ff.rw_strobe) && pout_ff.dq_oe_n;
  endproperty
  a_wr_psc: assert property (p_wr_psc) else $error("write reacted to strobe clock");

  property p_wr_mask;
    mem_we |-> state_ff == CARSP_ST_WR && pin_s2_ff.rw_strobe != CARSP_MASK_LVL;
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("masked byte written");

  c_read:   cover property (state_ff == CARSP_ST_RD && strobe_src ##[1:40] strobe_src);
  c_write:  cover property (state_ff == CARSP_ST_WR && bus_edge && !mem_we);
  c_extra:  cover property (cs_fall && extra_latency_req);
  c_abort:  cover property (state_ff == CARSP_ST_LAT && cs_rise);

endmodule

// ==== dv/carsp_host.sv ====
// Host bus master model driving select, clocks and data
`timescale 1ns/1ps
module carsp_host
  import carsp_pkg::*;
(
  // Clock
  input  wire logic clk_sys,
  // Host pin drive
  output carsp_pin_in_s hp
);
  logic [7:0] wdat [0:15];
  logic       wmsk [0:15];

  initial begin
    hp = CARSP_PIN_IN_RST;
    hp.bus_clk_comp = 1'b1;
  end

  // One bus clock edge, on reads a shifted edge a quarter period later
  task automatic step(input logic [7:0] d, input logic m, input logic rd);
    hp.dq <= d;
    hp.rw_strobe <= m;
    repeat (5) @(posedge clk_sys);
    hp.bus_clk <= ~hp.bus_clk;
    hp.bus_clk_comp <= hp.bus_clk;
    repeat (5) @(posedge clk_sys);
    if (rd) begin
      hp.shifted_clk <= ~hp.shifted_clk;
      hp.shifted_clk_comp <= hp.shifted_clk;
    end
  endtask

  // Even edge counts only, so clocks end low and no stray edge meets the select rise
  task automatic frame(input logic rd, input logic [7:0] a, input logic lat2, input int n);
    logic [47:0] ca;
    ca = {rd, 39'h0, a};
    hp.cs_n <= 1'b0;
    for (int i = 0; i < 6; i++)
      step(ca[47-8*i -: 8], i[0], rd);
    for (int i = 0; i < (lat2 ? 4 : 2) * CARSP_LAT_CLOCKS; i++)
      step(8'h00, 1'b0, rd);
    for (int i = 0; i < n; i++)
      step(rd ? 8'(i * 37) : wdat[i], rd ? i[0] : wmsk[i], rd);
    repeat (5) @(posedge clk_sys);
    hp.cs_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// ==== dv/test_center_aligned_read_strobe_port.sv ====
// Self-checking testbench for the read strobe port
`timescale 1ns/1ps
module test_center_aligned_read_strobe_port
  import carsp_pkg::*;
;
  logic           clk_sys;
  logic           rstn;
  logic           hw_reset_n;
  logic           extra_latency_req;
  carsp_pin_in_s  hp;
  carsp_pin_in_s  bus_pins;
  carsp_pin_out_s drive_pins;
  carsp_pin_out_s drive_se;
  int             failures;
  int             checked;
  logic [31:0]    seed;
  logic [7:0]     mem_m [0:255];
  logic [7:0]     got [$];
  logic [7:0]     got_se [$];
  logic           last_strb;
  logic           last_se;
  logic           flag_seen;
  logic           prev_oe_n;
  logic           sc_ff;
  int             sc_age;

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  carsp_host u_host (
    .clk_sys (clk_sys),
    .hp      (hp)
  );

  carsp_port #(
    .STROBE_OPT (1'b1),
    .DIFF_CLK   (1'b1)
  ) u_dut (
    .clk_sys           (clk_sys),
    .rstn              (rstn),
    .hw_reset_n        (hw_reset_n),
    .extra_latency_req (extra_latency_req),
    .bus_pins          (bus_pins),
    .drive_pins        (drive_pins)
  );

  // Single-ended clocks, strobe from the bus clock; it listens and never drives the bus
  carsp_port #(
    .STROBE_OPT (1'b0),
    .DIFF_CLK   (1'b0)
  ) u_dut_se (
    .clk_sys           (clk_sys),
    .rstn              (rstn),
    .hw_reset_n        (hw_reset_n),
    .extra_latency_req (extra_latency_req),
    .bus_pins          (bus_pins),
    .drive_pins        (drive_se)
  );

  // Wire level of the shared pins
  always_comb begin
    bus_pins = hp;
    if (drive_pins.dq_oe_n === 1'b0)
      bus_pins.dq = drive_pins.dq;
    if (drive_pins.rw_strobe_oe_n === 1'b0)
      bus_pins.rw_strobe = drive_pins.rw_strobe;
  end

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Read bytes are taken on every strobe toggle while data is driven
  always @(posedge clk_sys) begin
    sc_ff <= hp.shifted_clk;
    sc_age <= (hp.shifted_clk !== sc_ff) ? 1 : sc_age + 1;
    prev_oe_n <= drive_pins.rw_strobe_oe_n;
    last_strb <= drive_pins.rw_strobe;
    if (prev_oe_n === 1'b1 && drive_pins.rw_strobe_oe_n === 1'b0)
      flag_seen <= drive_pins.rw_strobe;
    if (drive_pins.dq_oe_n === 1'b0)
      chk(drive_pins.rw_strobe_oe_n === 1'b0, "strobe not driven");
    if (drive_pins.dq_oe_n === 1'b0 && drive_pins.rw_strobe !== last_strb) begin
      got.push_back(drive_pins.dq);
      chk(sc_age >= 2 && sc_age <= 6, "strobe edge off shifted clock");
    end
  end

  // Option off: one byte per bus clock edge of the data phase
  always @(posedge clk_sys) begin
    last_se <= drive_se.rw_strobe;
    if (drive_se.dq_oe_n === 1'b0 && drive_se.rw_strobe !== last_se)
      got_se.push_back(drive_se.dq);
  end

  task automatic run(input logic rd, input logic [7:0] a, input int n);
    logic lat2;
    seed = xs(seed);
    lat2 = seed[0];
    extra_latency_req <= lat2;
    flag_seen = 1'bx;
    got.delete();
    got_se.delete();
    u_host.frame(rd, a, lat2, n);
    chk(flag_seen === lat2, "latency flag");
    chk(drive_pins.dq_oe_n === 1'b1 && drive_pins.rw_strobe_oe_n === 1'b1, "held");
    if (rd) begin
      // The lagging copy of the last latency edge already lands in the read phase
      chk(got.size() == n + 1, "read count");
      for (int i = 0; i <= n && i < got.size(); i++)
        chk(got[i] === mem_m[8'(a + i)], "read data");
      chk(got_se.size() == n, "bus clock strobe count");
      for (int i = 0; i < n && i < got_se.size(); i++)
        chk(got_se[i] === mem_m[8'(a + i)], "bus clock strobe data");
    end
  endtask

  // Masked bytes keep their old contents in the model
  task automatic fill(input logic [7:0] a, input logic msk);
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      u_host.wdat[i] = seed[7:0];
      u_host.wmsk[i] = msk & seed[8];
      if (!(msk & seed[8]))
        mem_m[8'(a + i)] = seed[7:0];
    end
    run(1'b0, a, 10);
  endtask

  initial begin
    failures = 0;
    checked = 0;
    seed = 32'h28;
    rstn = 1'b0;
    hw_reset_n = 1'b1;
    extra_latency_req = 1'b0;
    last_strb = 1'b0;
    last_se = 1'b0;
    prev_oe_n = 1'b1;
    sc_ff = 1'b0;
    sc_age = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk(drive_pins === CARSP_PIN_OUT_RST, "reset pins");
    fill(8'hFC, 1'b0);
    fill(8'hFC, 1'b1);
    run(1'b1, 8'hFC, 8);
    run(1'b1, 8'hFE, 2);
    extra_latency_req <= 1'b0;
    fork
      u_host.frame(1'b1, 8'hFC, 1'b0, 8);
      begin
        repeat (230) @(posedge clk_sys);
        hw_reset_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(drive_pins.dq_oe_n === 1'b1 && drive_pins.rw_strobe_oe_n === 1'b1, "hw");
        hw_reset_n <= 1'b1;
      end
    join
    run(1'b1, 8'hFC, 8);
    wrap_up();
  end

  // Run needs about 8 us; a hang is cut at over twelve times that
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule
